// *** src/shcp_port.sv ***
// Serial host command port slave logic
`timescale 1ns/100ps
module shcp_port
(
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              clk_en_i,
    input  wire logic              chip_select_low_i,
    input  wire logic              serial_clock_i,
    input  wire logic              command_line_i,
    input  wire logic [7:0]        reply_byte_i,
    output logic                   reply_taken_o,
    output logic                   reply_out_line_o,
    output logic                   reply_out_line_oe_o,
    output shcp_pkg::shcp_cmd_s    cmd_o
);
    import shcp_pkg::*;

    // ******************************************************************
    // Input synchronisers
    // ******************************************************************
    logic [1:0] cs_sync_r;
    logic [1:0] sck_sync_r;
    logic [1:0] mosi_sync_r;
    logic       cs_d_r;
    logic       sck_d_r;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            cs_sync_r   <= 2'h3;
            sck_sync_r  <= 2'h0;
            mosi_sync_r <= 2'h0;
            cs_d_r      <= 1'h1;
            sck_d_r     <= 1'h0;
        end
        else if (clk_en_i)
        begin
            cs_sync_r   <= {cs_sync_r[0], chip_select_low_i};
            sck_sync_r  <= {sck_sync_r[0], serial_clock_i};
            mosi_sync_r <= {mosi_sync_r[0], command_line_i};
            cs_d_r      <= cs_sync_r[1];
            sck_d_r     <= sck_sync_r[1];
        end
    end

    logic cs_act;
    logic sck_rise;
    logic sck_fall;
    logic cs_start;
    logic cs_end;

    assign cs_act   = ~cs_sync_r[1];
    // Edges only count inside a frame, so idle polarity does not matter
    assign sck_rise = cs_act & ~cs_start & sck_sync_r[1] & ~sck_d_r;
    assign sck_fall = cs_act & ~cs_start & ~sck_sync_r[1] & sck_d_r;
    assign cs_start = cs_d_r & ~cs_sync_r[1];
    assign cs_end   = ~cs_d_r & cs_sync_r[1];

    // ******************************************************************
    // Command receive
    // ******************************************************************
    logic [7:0] sh_r;
    logic [2:0] bit_r;
    logic [1:0] cnt_r;
    logic [7:0] b0_r;
    logic [7:0] b1_r;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            sh_r  <= SHCP_RST_BYTE;
            bit_r <= 3'h0;
            cnt_r <= 2'h0;
            b0_r  <= SHCP_RST_BYTE;
            b1_r  <= SHCP_RST_BYTE;
        end
        else if (clk_en_i)
        begin
            if (cs_start)
            begin
                bit_r <= 3'h0;
                cnt_r <= 2'h0;
            end
            else if (sck_rise)
            begin
                sh_r  <= {sh_r[6:0], mosi_sync_r[1]};
                bit_r <= bit_r + 3'h1;
                if (bit_r == SHCP_BIT_MSB)
                begin
                    if (cnt_r == 2'h0)
                        b0_r <= {sh_r[6:0], mosi_sync_r[1]};
                    else if (cnt_r == 2'h1)
                        b1_r <= {sh_r[6:0], mosi_sync_r[1]};
                    if (cnt_r != 2'h3)
                        cnt_r <= cnt_r + 2'h1;
                end
            end
        end
    end

    // Command released only at end of frame
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            cmd_o <= '0;
        else if (clk_en_i)
        begin
            cmd_o.cmd_valid <= cs_end && (cnt_r != 2'h0);
            if (cs_end)
            begin
                cmd_o.cmd_count <= (cnt_r > 2'h2) ? 2'h2 : cnt_r;
                cmd_o.cmd_byte0 <= b0_r;
                cmd_o.cmd_byte1 <= b1_r;
            end
        end
    end

    // ******************************************************************
    // Reply transmit
    // ******************************************************************
    logic [7:0] tx_r;
    logic [2:0] tbit_r;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            tx_r             <= SHCP_RST_BYTE;
            tbit_r           <= 3'h0;
            reply_out_line_o <= 1'h0;
            reply_taken_o    <= 1'h0;
        end
        else if (clk_en_i)
        begin
            reply_taken_o <= 1'h0;
            if (cs_start)
            begin
                tx_r             <= {reply_byte_i[6:0], 1'h0};
                tbit_r           <= 3'h1;
                reply_out_line_o <= reply_byte_i[7];
                reply_taken_o    <= 1'h1;
            end
            else if (sck_fall && bit_r != 3'h0)
            begin
                // Shift after each falling edge once bit_r is nonzero
                if (tbit_r == 3'h0)
                begin
                    tx_r             <= {reply_byte_i[6:0], 1'h0};
                    reply_out_line_o <= reply_byte_i[7];
                    reply_taken_o    <= 1'h1;
                end
                else
                begin
                    tx_r             <= {tx_r[6:0], 1'h0};
                    reply_out_line_o <= tx_r[7];
                end
                tbit_r <= tbit_r + 3'h1;
            end
            else if (sck_fall && bit_r == 3'h0 && tbit_r == 3'h0)
            begin
                tx_r             <= {reply_byte_i[6:0], 1'h0};
                reply_out_line_o <= reply_byte_i[7];
                reply_taken_o    <= 1'h1;
                tbit_r           <= 3'h1;
            end
        end
    end

    // Drive only while selected
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            reply_out_line_oe_o <= 1'h0;
        else if (clk_en_i)
            reply_out_line_oe_o <= cs_act;
    end

    // ******************************************************************
    // Assertions
    // ******************************************************************
    property p_release;
        @(posedge clk_i) disable iff (sys_rst_i)
        (clk_en_i && cs_sync_r[1]) |=> !reply_out_line_oe_o;
    endproperty
    a_release: assert property (p_release) else $error("reply line driven while deselected");

    property p_hold_cmd;
        @(posedge clk_i) disable iff (sys_rst_i)
        cmd_o.cmd_valid |-> $past(cs_end);
    endproperty
    a_hold_cmd: assert property (p_hold_cmd) else $error("command released mid frame");

    property p_count;
        @(posedge clk_i) disable iff (sys_rst_i)
        (clk_en_i && sck_rise && bit_r == SHCP_BIT_MSB && cnt_r == 2'h0) |=> (cnt_r == 2'h1);
    endproperty
    a_count: assert property (p_count) else $error("byte count not advanced");

    property p_msb;
        @(posedge clk_i) disable iff (sys_rst_i)
        (clk_en_i && sck_rise) |=> (sh_r[0] == $past(mosi_sync_r[1]));
    endproperty
    a_msb: assert property (p_msb) else $error("sample not shifted in at rise");

    property p_fall_only;
        @(posedge clk_i) disable iff (sys_rst_i)
        (clk_en_i && !cs_start && !sck_fall) |=> $stable(tbit_r);
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("reply shifted off falling edge");

    property p_first_bit;
        @(posedge clk_i) disable iff (sys_rst_i)
        (clk_en_i && cs_start) |=> (reply_out_line_o == $past(reply_byte_i[7]));
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("reply not MSB first");

    property p_idle_edge;
        @(posedge clk_i) disable iff (sys_rst_i)
        (clk_en_i && sck_fall && bit_r == 3'h0 && tbit_r != 3'h0) |=> $stable(reply_out_line_o);
    endproperty
    a_idle_edge: assert property (p_idle_edge) else $error("leading fall shifted reply");
endmodule : shcp_port

// *** src/shcp_pkg.sv ***
// Package of constants and carriers for the serial host command port
package shcp_pkg;
    // ******************************************************************
    // Widths and timing
    // ******************************************************************
    localparam int unsigned SHCP_BYTE_W      = 8;
    localparam int unsigned SHCP_CLK_PERIOD_PS = 5000;
    localparam int unsigned SHCP_HIZ_MAX_PS    = 1000000;
    localparam int unsigned SHCP_HIZ_CYC       = SHCP_HIZ_MAX_PS / SHCP_CLK_PERIOD_PS;
    localparam logic [2:0]  SHCP_BIT_MSB       = 3'h7;
    localparam logic [7:0]  SHCP_RST_BYTE      = 8'h00;

    // ******************************************************************
    // Carriers
    // ******************************************************************
    typedef struct packed {
        logic       cmd_valid;
        logic [1:0] cmd_count;
        logic [7:0] cmd_byte0;
        logic [7:0] cmd_byte1;
    } shcp_cmd_s;

    typedef struct packed {
        logic       data_out;
        logic       data_oe;
    } shcp_pin_s;
endpackage : shcp_pkg

// *** verif/shcp_host.sv ***
// Host side serial master model
`timescale 1ns/100ps
module shcp_host
(
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    initial
    begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end
    // One frame of nb bits, command MSB first, reply sampled on each rise
    task automatic frame(input bit cpol, input int nb, input logic [23:0] cmd,
                         output logic [23:0] rep);
        sclk_o = cpol;
        cs_n_o = 1'b0;
        // Half step keeps pin changes off rising clock edges
        #100.5;
        for (int i = 0; i < nb; i++)
        begin
            sclk_o = 1'b0;
            mosi_o = cmd[23-i];
            #32 sclk_o = 1'b1;
            rep = {rep[22:0], miso_i};
            #32;
        end
        sclk_o = cpol;
        #100 cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
    endtask : frame
endmodule : shcp_host

// *** verif/test_shcp_port.sv ***
// Self-checking bench for the serial host command port
`timescale 1ns/100ps
module test_shcp_port;
    import shcp_pkg::*;
    logic       clk_i      = 1'b0;
    logic       sys_rst_i  = 1'b1;
    logic [7:0] reply_byte = 8'h00;
    logic       cs_n, sclk, mosi, rout, roe, taken;
    wire        miso       = roe ? rout : ~rout;
    shcp_cmd_s  cmd, e_c, g_c;
    shcp_cmd_s  exp_q[$];
    logic [7:0] rq[$];
    int         failures   = 0;
    int         n_compared = 0;
    int         cyc        = 0;
    always #2.5 clk_i = ~clk_i;
    shcp_host u_host (.cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi), .miso_i(miso));
    shcp_port u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
        .chip_select_low_i(cs_n), .serial_clock_i(sclk), .command_line_i(mosi),
        .reply_byte_i(reply_byte), .reply_taken_o(taken), .reply_out_line_o(rout),
        .reply_out_line_oe_o(roe), .cmd_o(cmd));
    task automatic check_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask : check_bit
    task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask : check_byte
    task automatic check_cmd(input shcp_cmd_s e, input shcp_cmd_s g);
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] cmd expected %0h seen %0h", e, g);
        end
    endtask : check_cmd
    task automatic print_verdict;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            $display("[FAIL] timeout expected %0d seen %0d", 20000, cyc);
            print_verdict();
        end
    end
    // Next reply byte after each load
    always @(posedge clk_i)
    begin
        #1;
        if (taken === 1'b1)
        begin
            rq.push_back(reply_byte);
            reply_byte = 8'($urandom);
        end
    end
    // Command watcher
    always @(posedge clk_i)
    begin
        #1;
        if (cmd.cmd_valid === 1'b1)
        begin
            check_bit("select at cmd", 1'b1, cs_n);
            e_c = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
            g_c = cmd;
            if (e_c.cmd_count != 2'h2)
            begin
                e_c.cmd_byte1 = 8'h00;
                g_c.cmd_byte1 = 8'h00;
            end
            check_cmd(e_c, g_c);
        end
    end
    initial
    begin
        logic [23:0] c, r;
        int          nb, nf;
        void'($urandom(64654));
        repeat (2) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        for (int k = 0; k < 10; k++)
        begin
            @(posedge clk_i);
            #1;
            nb = (k % 5 == 3) ? 4 : (k % 5 == 4) ? 12 : 8 * (k % 5 + 1);
            nf = nb / 8;
            c  = 24'($urandom);
            if (nf > 0)
                exp_q.push_back({1'b1, (nf > 1) ? 2'h2 : 2'h1, c[23:16], c[15:8]});
            rq.delete();
            fork
                u_host.frame(k[0], nb, c, r);
                #99 check_bit("oe on", 1'b1, roe);
            join
            for (int j = 0; j < nf; j++)
                check_byte("reply", rq[j], 8'(r >> (nb - 8 * j - 8)));
            #1000 check_bit("oe off", 1'b0, roe);
        end
        check_byte("left", 8'h00, 8'(exp_q.size()));
        print_verdict();
    end
endmodule : test_shcp_port
